// [hw/acs_pkg.sv]
/*
  Shared constants for the ADC conversion sequencer: bus map, module
  register layout, field positions, reset values and timing.
  Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package acs_pkg;

  // ==========================================================================
  // Bus map (port base as a byte address, other registers as word indices).
  localparam logic [6:0] ADDR_PORT_BASE = 7'h00;
  localparam logic [4:0] IDX_POWER      = 5'h10;
  localparam logic [4:0] IDX_DBG_CTRL   = 5'h11;
  localparam logic [4:0] IDX_STATUS     = 5'h12;
  localparam logic [4:0] IDX_ACC        = 5'h13;
  localparam logic [4:0] IDX_PTR        = 5'h14;
  localparam logic [4:0] IDX_INSTR      = 5'h15;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ==========================================================================
  // CPU ports and the three that carry module access.
  localparam int         NUM_PORTS      = 16;
  localparam logic [3:0] PORT_MOD_ADDR  = 4'hD;
  localparam logic [3:0] PORT_MOD_DATA  = 4'hE;
  localparam logic [3:0] PORT_MOD_CMD   = 4'hF;
  localparam int         CMD_WRITE_BIT  = 0;

  // ==========================================================================
  // ADC module registers.
  localparam int         NUM_MOD_REGS   = 10;
  localparam logic [3:0] MREG_CONTROL   = 4'h0;
  localparam logic [3:0] MREG_CFG_A0    = 4'h1;
  localparam logic [3:0] MREG_CFG_B0    = 4'h4;
  localparam logic [3:0] MREG_DATA0     = 4'h7;
  localparam int         CTL_START_LSB  = 0;
  localparam int         CTL_SE_LSB     = 4;
  localparam int         CTL_DIV_LSB    = 8;
  localparam int         CFGA_RES_LSB   = 0;
  localparam int         CFGA_GAIN_LSB  = 3;
  localparam int         CFGA_REF_LSB   = 8;
  localparam int         CFGB_OFS_LSB   = 0;
  localparam logic [15:0] MOD_RESET     = 16'h0000;

  // ==========================================================================
  // Channel and reference codes.
  localparam logic [1:0] CH_ONE         = 2'h0;
  localparam logic [1:0] CH_TWO         = 2'h1;
  localparam logic [1:0] CH_TEMP        = 2'h2;
  localparam logic [1:0] REF_SUPPLY     = 2'h0;
  localparam logic [1:0] REF_EXT_X2     = 2'h1;
  localparam logic [1:0] REF_BANDGAP    = 2'h2;
  localparam int         MIN_RES_BITS   = 9;

  // ==========================================================================
  // Timing.
  localparam int         CLK_PERIOD_NS  = 20;
  localparam int         POR_HOLD_US    = 250;
  localparam int         POR_HOLD_CYC   = (POR_HOLD_US * 1000) / CLK_PERIOD_NS;
  localparam int         ADC_DIV_MIN    = 4;
  localparam int         ADC_CLKS_BASE  = 16;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_LATCH   = 2'b10,
    ST_RESUME  = 2'b11
  } acs_seq_type;

endpackage

// [hw/acs_sequencer.sv]
/*
  ADC conversion sequencer: CPU port file, indirect module register access,
  conversion start/halt/latch/resume sequencing, power-on hold and debug view.
  Assumes an AXI4-Lite master, a front end that presents its decimated word
  on convResult, and supply monitors that are synchronous to sys_clk.
*/
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int POR_HOLD_CYCLES = POR_HOLD_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [6:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        supplyGood,
  input  wire logic [15:0] convResult,
  input  wire logic [15:0] cpuAccValue,
  input  wire logic [15:0] cpuPtrValue,
  input  wire logic [15:0] cpuInstrWord,
  output logic             cpuClkEnable,
  output logic             cpuHalted,
  output logic             cpuReset,
  output logic             convActive,
  output logic [1:0]       convChannel,
  output logic [1:0]       refSelect,
  output logic [3:0]       singleEndedSel,
  output logic [4:0]       gainSelect,
  output logic [7:0]       coarseOffset,
  output logic [15:0]      modulePower
);

  // ==========================================================================
  // Elaboration checks.
  if (POR_HOLD_CYCLES < 1 || POR_HOLD_CYCLES > 16383) begin : g_chk
    $error("POR_HOLD_CYCLES must lie between 1 and 16383");
  end

  // ==========================================================================
  // State record.
  typedef struct packed {
    logic                   awHeld;
    logic [6:0]             awAddr;
    logic                   wHeld;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   awReady;
    logic                   wReady;
    logic                   bValid;
    logic [1:0]             bResp;
    logic                   arReady;
    logic                   rValid;
    logic [31:0]            rData;
    logic [1:0]             rResp;
    logic [15:0][15:0]      ports;
    logic [9:0][15:0]       modRegs;
    logic [15:0]            power;
    logic                   dbgHalt;
    acs_seq_type            seq;
    logic [1:0]             chan;
    logic [23:0]            convCnt;
    logic [13:0]            porCnt;
    logic                   cpuReset;
    logic                   cpuHalt;
    logic                   clkEn;
    logic [1:0]             refSel;
    logic [3:0]             seSel;
    logic [4:0]             gain;
    logic [7:0]             offset;
  } acs_state_type;

  acs_state_type state_reg;
  acs_state_type state_next;

  // Decode helpers shared by the update logic and the checks below.
  logic        wrCommit;
  logic [4:0]  wrIdx;
  logic [4:0]  rdIdx;
  logic        startReq;
  logic [1:0]  startChan;
  logic [15:0] maskedResult;
  logic [23:0] convCycles;
  logic        viewOpen;

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    logic [15:0] portWord;
    logic [15:0] ctlWord;
    logic [3:0]  modIdx;
    logic [2:0]  res;
    logic [2:0]  divSel;
    logic [1:0]  cfgIdx;
    portWord = 16'h0000;
    ctlWord  = 16'h0000;
    modIdx   = 4'h0;
    res      = 3'h0;
    divSel   = 3'h0;
    cfgIdx   = 2'h0;
    state_next = state_reg;
    startReq   = 1'b0;
    startChan  = CH_ONE;

    // Address and data are captured independently; the write completes once
    // both are held and no response is pending.
    if (s_axi_awvalid && state_reg.awReady) begin
      state_next.awHeld = 1'b1;
      state_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wReady) begin
      state_next.wHeld = 1'b1;
      state_next.wData = s_axi_wdata;
      state_next.wStrb = s_axi_wstrb;
    end
    wrCommit = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
    wrIdx    = state_reg.awAddr[6:2];
    rdIdx    = s_axi_araddr[6:2];
    viewOpen = state_reg.cpuHalt || state_reg.dbgHalt;

    if (s_axi_bvalid && s_axi_bready) begin
      state_next.bValid = 1'b0;
    end
    if (wrCommit) begin
      state_next.awHeld = 1'b0;
      state_next.wHeld  = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp  = RESP_OKAY;
      portWord = state_reg.ports[wrIdx[3:0]];
      if (state_reg.wStrb[0]) begin
        portWord[7:0] = state_reg.wData[7:0];
      end
      if (state_reg.wStrb[1]) begin
        portWord[15:8] = state_reg.wData[15:8];
      end
      if (wrIdx < 5'(NUM_PORTS)) begin
        // Ports are plain storage; only the command port has a side effect.
        state_next.ports[wrIdx[3:0]] = portWord;
        if (wrIdx[3:0] == PORT_MOD_CMD) begin
          modIdx = state_reg.ports[PORT_MOD_ADDR][3:0];
          // The whole index word is decoded, so a high index never aliases.
          if (state_reg.ports[PORT_MOD_ADDR]
              >= 16'(NUM_MOD_REGS)) begin
            state_next.ports[PORT_MOD_DATA] = 16'h0000;
          end else if (!portWord[CMD_WRITE_BIT]) begin
            state_next.ports[PORT_MOD_DATA] = state_reg.modRegs[modIdx];
          end else if (modIdx < MREG_DATA0
                       && state_reg.seq == ST_IDLE) begin
            // Module writes go through the address/data ports only.
            state_next.modRegs[modIdx] =
              state_reg.ports[PORT_MOD_DATA];
            ctlWord = state_reg.ports[PORT_MOD_DATA];
            if (modIdx == MREG_CONTROL && !state_reg.cpuReset
                && ctlWord[CTL_START_LSB +: 3] != 3'b000) begin
              startReq = 1'b1;
            end
            // Fixed priority when several start bits are written at once.
            if (ctlWord[CTL_START_LSB]) begin
              startChan = CH_ONE;
            end else if (ctlWord[CTL_START_LSB + 1]) begin
              startChan = CH_TWO;
            end else begin
              startChan = CH_TEMP;
            end
          end
        end
      end else if (wrIdx == IDX_POWER) begin
        state_next.power = portWord;
      end else if (wrIdx == IDX_DBG_CTRL) begin
        state_next.dbgHalt = portWord[0];
      end else if (wrIdx > IDX_INSTR || wrIdx == IDX_STATUS) begin
        state_next.bResp = RESP_SLVERR;
      end else begin
        state_next.bResp = RESP_SLVERR;
      end
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_rvalid && s_axi_rready) begin
      state_next.rValid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arReady) begin
      state_next.rValid = 1'b1;
      state_next.rResp  = RESP_OKAY;
      state_next.rData  = 32'h0000_0000;
      if (rdIdx < 5'(NUM_PORTS)) begin
        state_next.rData = {16'h0000, state_reg.ports[rdIdx[3:0]]};
      end else if (rdIdx == IDX_POWER) begin
        state_next.rData = {16'h0000, state_reg.power};
      end else if (rdIdx == IDX_DBG_CTRL) begin
        state_next.rData = {31'h0000_0000, state_reg.dbgHalt};
      end else if (rdIdx == IDX_STATUS) begin
        state_next.rData = {28'h000_0000, state_reg.clkEn,
                            state_reg.cpuReset, state_reg.cpuHalt,
                            state_reg.seq != ST_IDLE};
      end else if (rdIdx == IDX_ACC) begin
        // CPU internals are hidden unless a conversion or the debug halt stops the CPU.
        state_next.rData = viewOpen ? {16'h0000, cpuAccValue}
                                    : 32'h0000_0000;
      end else if (rdIdx == IDX_PTR) begin
        state_next.rData = viewOpen ? {16'h0000, cpuPtrValue}
                                    : 32'h0000_0000;
      end else if (rdIdx == IDX_INSTR) begin
        state_next.rData = viewOpen ? {16'h0000, cpuInstrWord}
                                    : 32'h0000_0000;
      end else begin
        state_next.rResp = RESP_SLVERR;
      end
    end

    // Resolution keeps the top 9 to 16 bits of the two's-complement word;
    // the temperature word is already sign plus fifteen bits.
    cfgIdx = state_reg.chan;
    res    = state_reg.modRegs[MREG_CFG_A0 + 4'(cfgIdx)][CFGA_RES_LSB +: 3];
    maskedResult = convResult & (16'hFFFF << (3'h7 - res));
    divSel = state_reg.modRegs[MREG_CONTROL][CTL_DIV_LSB +: 3];
    convCycles = 24'(ADC_DIV_MIN << divSel) * 24'(ADC_CLKS_BASE << res);

    // Conversion sequence.
    case (state_reg.seq)
      ST_IDLE: begin
        if (startReq) begin
          state_next.seq     = ST_CONVERT;
          state_next.chan    = startChan;
          state_next.cpuHalt = 1'b1;
          state_next.convCnt = 24'h00_0000;
        end
      end
      ST_CONVERT: begin
        // Duration scales with resolution and the ADC clock divisor.
        state_next.convCnt = state_reg.convCnt + 24'h00_0001;
        if (state_reg.convCnt >= convCycles - 24'h00_0001) begin
          state_next.seq = ST_LATCH;
        end
      end
      ST_LATCH: begin
        state_next.modRegs[MREG_DATA0 + 4'(state_reg.chan)] =
          maskedResult;
        state_next.modRegs[MREG_CONTROL][CTL_START_LSB +: 3] =
          3'b000;
        state_next.seq = ST_RESUME;
      end
      ST_RESUME: begin
        state_next.cpuHalt = 1'b0;
        state_next.seq     = ST_IDLE;
      end
      default: begin
        state_next.seq = ST_IDLE;
      end
    endcase

    // Front-end steering follows the control and per-channel configuration.
    cfgIdx = (state_next.seq == ST_IDLE) ? CH_ONE : state_next.chan;
    state_next.seSel  = state_next.modRegs[MREG_CONTROL][CTL_SE_LSB +: 4];
    state_next.gain   =
      state_next.modRegs[MREG_CFG_A0 + 4'(cfgIdx)][CFGA_GAIN_LSB +: 5];
    state_next.offset =
      state_next.modRegs[MREG_CFG_B0 + 4'(cfgIdx)][CFGB_OFS_LSB +: 8];
    if (cfgIdx == CH_TEMP) begin
      state_next.refSel = REF_BANDGAP;
    end else begin
      state_next.refSel =
        state_next.modRegs[MREG_CFG_A0 + 4'(cfgIdx)][CFGA_REF_LSB +: 2];
      if (state_next.refSel > REF_BANDGAP) begin
        state_next.refSel = REF_BANDGAP;
      end
    end

    // Power-on hold: ports, power and debug halt default and the CPU is held in reset while supplies are short.
    if (!supplyGood) begin
      state_next.porCnt   = 14'h0000;
      state_next.cpuReset = 1'b1;
      state_next.power    = 16'h0000;
      state_next.ports    = '0;
      state_next.dbgHalt  = 1'b0;
    end else if (state_reg.cpuReset) begin
      state_next.porCnt = state_reg.porCnt + 14'h0001;
      if (state_reg.porCnt >= 14'(POR_HOLD_CYCLES - 1)) begin
        state_next.cpuReset = 1'b0;
      end
    end

    state_next.clkEn   = !state_next.cpuHalt && !state_next.dbgHalt
                         && !state_next.cpuReset;
    state_next.awReady = !state_next.awHeld && !state_next.bValid;
    state_next.wReady  = !state_next.wHeld && !state_next.bValid;
    state_next.arReady = !state_next.rValid;
  end

  // ==========================================================================
  // State register. Control starts in the held-in-reset condition.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg          <= '0;
      state_reg.seq      <= ST_IDLE;
      state_reg.cpuReset <= 1'b1;
      state_reg.modRegs  <= {NUM_MOD_REGS{MOD_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs come straight from the state record.
  assign s_axi_awready  = state_reg.awReady;
  assign s_axi_wready   = state_reg.wReady;
  assign s_axi_bvalid   = state_reg.bValid;
  assign s_axi_bresp    = state_reg.bResp;
  assign s_axi_arready  = state_reg.arReady;
  assign s_axi_rvalid   = state_reg.rValid;
  assign s_axi_rdata    = state_reg.rData;
  assign s_axi_rresp    = state_reg.rResp;
  assign cpuClkEnable   = state_reg.clkEn;
  assign cpuHalted      = state_reg.cpuHalt;
  assign cpuReset       = state_reg.cpuReset;
  assign convActive     = state_reg.cpuHalt;
  assign convChannel    = state_reg.chan;
  assign refSelect      = state_reg.refSel;
  assign singleEndedSel = state_reg.seSel;
  assign gainSelect     = state_reg.gain;
  assign coarseOffset   = state_reg.offset;
  assign modulePower    = state_reg.power;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_start_halts: assert property (startReq |=> cpuHalted && !cpuClkEnable)
    else $error("conversion start did not halt the CPU");
  a_start_cause: assert property ($rose(cpuHalted) |-> $past(startReq))
    else $error("conversion began without a start write");
  a_bits_clear: assert property (state_reg.seq == ST_LATCH |=>
      state_reg.modRegs[MREG_CONTROL][2:0] == 3'b000)
    else $error("start bits not cleared at completion");
  a_data_latch: assert property (state_reg.seq == ST_LATCH |=>
      state_reg.modRegs[MREG_DATA0 + 4'($past(state_reg.chan))]
      == $past(maskedResult))
    else $error("result not latched into channel data");
  a_resume_order: assert property ($fell(cpuHalted) |->
      $past(state_reg.seq, 2) == ST_LATCH)
    else $error("CPU resumed before latch and clear");
  a_temp_ref: assert property (cpuHalted && convChannel == CH_TEMP
      && state_reg.seq != ST_RESUME |-> refSelect == REF_BANDGAP)
    else $error("temperature conversion without bandgap reference");
  a_power_clear: assert property (!supplyGood |=>
      cpuReset && modulePower == 16'h0000)
    else $error("power bits not cleared below threshold");
  a_por_hold: assert property ($fell(cpuReset) |->
      $past(state_reg.porCnt) == 14'(POR_HOLD_CYCLES - 1))
    else $error("CPU released before power-on hold elapsed");
  a_debug_hidden: assert property (s_axi_arvalid && s_axi_arready
      && rdIdx == IDX_ACC && !viewOpen |=> s_axi_rdata == 32'h0000_0000)
    else $error("accumulator visible while CPU running");

endmodule

// [verification/acs_cpu_model.sv]
/*
  Behavioural model of the embedded CPU on the far side of the sequencer.
  Assumes the sequencer gates its clock with cpuClkEnable and cpuReset.
*/
`timescale 1ns/1ps
module acs_cpu_model (
  input  wire logic   sys_clk,
  input  wire logic   cpuClkEnable,
  input  wire logic   cpuReset,
  output logic [15:0] cpuAccValue,
  output logic [15:0] cpuPtrValue,
  output logic [15:0] cpuInstrWord
);
  // ==========================================================================
  // Program execution
  // State moves only on a gated-on clock, so a halt freezes what the debug
  // view shows; a model that kept running would hide a broken clock gate.
  always @(posedge sys_clk) begin
    if (cpuReset !== 1'b0) begin
      cpuAccValue <= 16'h0001;
      cpuPtrValue <= 16'h0000;
      cpuInstrWord <= 16'h8000;
    end else if (cpuClkEnable === 1'b1) begin
      cpuAccValue <= cpuAccValue + 16'h0003;
      cpuPtrValue <= cpuPtrValue ^ 16'h5A5A;
      cpuInstrWord <= {cpuInstrWord[14:0], ~cpuInstrWord[15]};
    end
  end
endmodule

// [verification/adc_conversion_sequencer_bench.sv]
/*
  Self-checking bench for the conversion sequencer over AXI4-Lite.
  Assumes the package map and a CPU model driving the debug values.
*/
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  import acs_pkg::*;
  localparam int HOLD = 20;
  logic sys_clk = 1'b0, rst_n = 1'b0, supplyGood = 1'b1;
  logic [6:0] s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, convChannel, refSelect;
  logic [15:0] convResult = 16'h0000, cpuAccValue, cpuPtrValue, cpuInstrWord;
  logic [15:0] modulePower;
  logic cpuClkEnable, cpuHalted, cpuReset, convActive;
  logic [3:0] singleEndedSel;
  logic [4:0] gainSelect;
  logic [7:0] coarseOffset;
  int nFail = 0, totalChecks = 0;
  logic [1:0] bResp;
  int portModel [16];

  // ==========================================================================
  // Clock, design and CPU model
  always #10 sys_clk = ~sys_clk;
  acs_sequencer #(.POR_HOLD_CYCLES(HOLD)) i_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .supplyGood(supplyGood),
    .convResult(convResult), .cpuAccValue(cpuAccValue),
    .cpuPtrValue(cpuPtrValue), .cpuInstrWord(cpuInstrWord),
    .cpuClkEnable(cpuClkEnable), .cpuHalted(cpuHalted), .cpuReset(cpuReset),
    .convActive(convActive), .convChannel(convChannel),
    .refSelect(refSelect), .singleEndedSel(singleEndedSel),
    .gainSelect(gainSelect), .coarseOffset(coarseOffset),
    .modulePower(modulePower));
  acs_cpu_model i_cpu (.sys_clk(sys_clk), .cpuClkEnable(cpuClkEnable),
    .cpuReset(cpuReset), .cpuAccValue(cpuAccValue),
    .cpuPtrValue(cpuPtrValue), .cpuInstrWord(cpuInstrWord));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Each half is released on its own handshake, since the slave may take
  // address and data at different edges.
  task automatic axw(input logic [6:0] a, input logic [31:0] d);
    bit pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge sys_clk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    bResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [6:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Module registers go through the address, data and command ports.
  task automatic modw(input logic [31:0] idx, input logic [31:0] val);
    axw(7'h34, idx);
    axw(7'h38, val);
    axw(7'h3C, 32'h0000_0001);
  endtask
  task automatic modr(input logic [31:0] idx, output logic [31:0] d);
    logic [1:0] r;
    axw(7'h34, idx);
    axw(7'h3C, 32'h0000_0000);
    axr(7'h38, d, r);
  endtask

  // ==========================================================================
  // Watchdog: far beyond the longest conversion sequence.
  initial begin
    #1_000_000;
    nFail++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] v, mask;
    int n, res, gain, ofs, refc, cyc;
    void'($urandom(32'h8c4d));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    n = 0;
    while (cpuReset !== 1'b0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= HOLD && n <= HOLD + 3), 32'h0000_0001);
    for (int p = 0; p < 13; p++) begin
      portModel[p] = $urandom();
      axw(7'(p * 4), 32'(portModel[p]));
    end
    for (int p = 0; p < 13; p++) begin
      axr(7'(p * 4), d, r);
      chk(d, 32'(portModel[p]) & 32'h0000_FFFF);
    end
    for (int ch = 0; ch < 3; ch++) begin
      res = $urandom_range(0, 7);
      gain = $urandom_range(0, 31);
      ofs = $urandom_range(0, 255);
      refc = (ch == 2) ? $urandom_range(0, 3) : $urandom_range(0, 2);
      cyc = 4 * (16 << res);
      modw(32'(1 + ch), 32'(res | (gain << 3) | (refc << 8)));
      modw(32'(4 + ch), 32'(ofs));
      v = 16'($urandom());
      convResult <= v;
      modw(32'h0000_0000, 32'(1 << ch));
      for (n = 0; n < 50 && cpuHalted !== 1'b1; n++) @(posedge sys_clk);
      chk({convActive, cpuClkEnable}, 32'h0000_0002);
      chk(convChannel, 32'(ch));
      chk(refSelect, (ch == 2) ? REF_BANDGAP : 2'(refc));
      chk({gainSelect, coarseOffset}, 32'((gain << 8) | ofs));
      axr(7'h4C, d, r);
      chk(d, {16'h0000, cpuAccValue});
      for (n = 0; n < 20000 && cpuHalted !== 1'b0; n++) @(posedge sys_clk);
      chk(32'(n >= cyc - 12 && n <= cyc + 4), 32'h0000_0001);
      chk(cpuClkEnable, 32'h0000_0001);
      mask = 16'hFFFF << (7 - res);
      modr(32'(7 + ch), d);
      chk(d, {16'h0000, v & mask});
      modr(32'h0000_0000, d);
      chk(d[2:0], 32'h0000_0000);
    end
    modw(32'h0000_0000, 32'h0000_0050);
    chk({cpuHalted, singleEndedSel}, 32'h0000_0005);
    axr(7'h4C, d, r);
    chk(d, 32'h0000_0000);
    axr(7'h58, d, r);
    chk(r, RESP_SLVERR);
    modr(32'h0000_000A, d);
    chk(d, 32'h0000_0000);
    axw(7'h40, 32'h0000_00A5);
    chk(modulePower, 32'h0000_00A5);
    chk(bResp, RESP_OKAY);
    axw(7'h48, 32'h0000_0001);
    chk(bResp, RESP_SLVERR);
    axw(7'h44, 32'h0000_0001);
    axr(7'h50, d, r);
    chk({cpuClkEnable, d[15:0]}, {1'b0, cpuPtrValue});
    axw(7'h44, 32'h0000_0000);
    chk(cpuClkEnable, 32'h0000_0001);
    supplyGood <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({cpuReset, modulePower}, 32'h0001_0000);
    results();
  end
endmodule
